// ===== hdl/stc_pkg.sv
package stc_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLK_PERIOD_PS = 4000;
    localparam int unsigned BURST_TIME_US = 20;
    localparam int unsigned BURST_CYC_DEF =
        (BURST_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned BURST_CNT_W   = 13;
    localparam logic [3:0]  STRAP_LAST    = 4'hf;
    localparam logic [9:0]  SLEEP_LAST    = 10'h1ff;
    localparam logic [3:0]  IGNORE_SW     = 4'h8;
    localparam logic [4:0]  WAKE_LAST     = 5'h17;

    // ************************************************************
    // Pin inputs, strap codes and duty thresholds
    // ************************************************************
    localparam int unsigned NPIN     = 5;
    localparam int unsigned PIN_ENON = 0;
    localparam int unsigned PIN_ENOF = 1;
    localparam int unsigned PIN_VCC  = 2;
    localparam int unsigned PIN_DSA  = 3;
    localparam int unsigned PIN_DSB  = 4;

    localparam logic [1:0] Q_SHORT = 2'h0;
    localparam logic [1:0] Q_R100  = 2'h1;
    localparam logic [1:0] Q_R180  = 2'h2;
    localparam logic [1:0] Q_OPEN  = 2'h3;
    localparam logic [7:0] LVL_T1  = 8'h20;
    localparam logic [7:0] LVL_T2  = 8'h60;
    localparam logic [7:0] LVL_T3  = 8'ha0;

    localparam logic [6:0] DUTY_0  = 7'h00;
    localparam logic [6:0] DUTY_25 = 7'h19;
    localparam logic [6:0] DUTY_40 = 7'h28;
    localparam logic [6:0] DUTY_55 = 7'h37;
    localparam logic [6:0] DUTY_60 = 7'h3c;
    localparam logic [6:0] DUTY_65 = 7'h41;
    localparam logic [6:0] DUTY_70 = 7'h46;
    localparam logic [6:0] DUTY_75 = 7'h4b;
    localparam logic [6:0] DUTY_80 = 7'h50;

    // ************************************************************
    // Register port
    // ************************************************************
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STAT = 4'h4;
    localparam int unsigned CTRL_INH   = 0;
    localparam int unsigned STAT_SLEEP = 0;
    localparam int unsigned STAT_ENC   = 1;
    localparam int unsigned STAT_PRC   = 3;
    localparam int unsigned STAT_LOWP  = 5;
    localparam int unsigned STAT_GATE  = 6;
    localparam int unsigned STAT_ENTRY = 8;
    localparam int unsigned STAT_EXIT  = 16;

    typedef enum logic [2:0] {S_OFF, S_STRAP, S_RUN, S_LOW, S_WAKE} stc_state_e;

    function automatic logic [6:0] stc_exit_duty(input logic       slp,
                                                 input logic [1:0] enc,
                                                 input logic [1:0] prc);
        logic [6:0] d;
        d = DUTY_0;
        case (prc)
            Q_SHORT: d = !slp ? DUTY_80 : (enc == Q_R180) ? DUTY_75 : DUTY_80;
            Q_R100:  d = !slp ? DUTY_75 : (enc == Q_R180) ? DUTY_70 : DUTY_75;
            Q_R180:  d = !slp ? DUTY_65 : (enc == Q_R180) ? DUTY_60 : DUTY_65;
            default: d = !slp ? DUTY_0  : (enc == Q_R180) ? DUTY_55 : DUTY_60;
        endcase
        return d;
    endfunction : stc_exit_duty

endpackage : stc_pkg

// ===== hdl/stc_quant.sv
`timescale 1ns/1ps
module stc_quant
    import stc_pkg::*;
(
    input  wire logic [7:0] level,
    output logic      [1:0] code
);
    // Strap level rises with the strap resistance; above the top step the pin is open.
    always_comb begin
        if (level < LVL_T1) begin
            code = Q_SHORT;
        end else if (level < LVL_T2) begin
            code = Q_R100;
        end else if (level < LVL_T3) begin
            code = Q_R180;
        end else begin
            code = Q_OPEN;
        end
    end
endmodule : stc_quant

// ===== hdl/stc_top.sv
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module stc_top
    import stc_pkg::*;
#(
    parameter int unsigned BURST_CYC = BURST_CYC_DEF
)
(
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        en_above_on,
    input  wire logic        en_below_off,
    input  wire logic        supply_in_range,
    input  wire logic        drain_sense_a,
    input  wire logic        drain_sense_b,
    input  wire logic [7:0]  en_strap_level,
    input  wire logic [7:0]  threshold_strap_level,
    input  wire logic [6:0]  duty_pct,
    input  wire logic        duty_valid,
    input  wire logic [3:0]  bus_addr,
    input  wire logic [31:0] bus_wdata,
    input  wire logic        bus_wr,
    input  wire logic        bus_rd,
    output logic      [31:0] bus_rdata,
    output logic             gate_enable,
    output logic             low_power,
    output logic             sleep_enabled,
    output logic      [6:0]  entry_duty,
    output logic      [6:0]  exit_duty,
    output logic             en_sense_full,
    output logic             threshold_strap_sense_current
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        stc_state_e            state;
        logic [NPIN-1:0]       s1;
        logic [NPIN-1:0]       s2;
        logic [NPIN-1:0]       s3;
        logic [NPIN-1:0]       filt;
        logic [3:0]            strap_cnt;
        logic [9:0]            sleep_cnt;
        logic [BURST_CNT_W-1:0] burst_cnt;
        logic [3:0]            ign_cnt;
        logic [4:0]            wake_cnt;
        logic                  sleep_en;
        logic [1:0]            en_code;
        logic [1:0]            thr_code;
        logic [6:0]            entry_thr;
        logic [6:0]            exit_thr;
        logic                  en_full;
        logic                  thr_on;
        logic                  gate_en;
        logic                  low_pwr;
        logic                  gate_inhibit;
        logic [31:0]           rdata;
    } stc_state_s;

    stc_state_s     cs_ff;
    stc_state_s     nxt_cs;
    logic           rst_a_ff;
    logic           rst_b_ff;
    logic [1:0]     qcode [2];
    logic [7:0]     qlvl  [2];
    logic           both_high;
    logic           burst_det;
    logic           go_off;

    // Reset is released through two flops so every state flop leaves reset on one edge.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rst_a_ff <= 1'b0;
            rst_b_ff <= 1'b0;
        end else begin
            rst_a_ff <= 1'b1;
            rst_b_ff <= rst_a_ff;
        end
    end

    assign qlvl[0] = en_strap_level;
    assign qlvl[1] = threshold_strap_level;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_quant
            stc_quant u_quant (
                .level (qlvl[gi]),
                .code  (qcode[gi])
            );
        end
    endgenerate

    assign both_high = cs_ff.filt[PIN_DSA] & cs_ff.filt[PIN_DSB];
    // Qualified by the live senses, so the saturated count never outlives the burst.
    assign burst_det = both_high && (cs_ff.burst_cnt == BURST_CNT_W'(BURST_CYC));
    assign go_off    = !cs_ff.filt[PIN_VCC] || cs_ff.filt[PIN_ENOF];

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        nxt_cs       = cs_ff;
        nxt_cs.s1    = {drain_sense_b, drain_sense_a, supply_in_range, en_below_off,
                        en_above_on};
        nxt_cs.s2    = cs_ff.s1;
        nxt_cs.s3    = cs_ff.s2;
        nxt_cs.rdata = 32'h0000_0000;
        for (int i = 0; i < NPIN; i++) begin
            if (cs_ff.s2[i] == cs_ff.s3[i]) begin
                nxt_cs.filt[i] = cs_ff.s3[i];
            end
        end

        // Saturating count of time with both drain senses above the arming level.
        if (!both_high) begin
            nxt_cs.burst_cnt = '0;
        end else if (!burst_det) begin
            nxt_cs.burst_cnt = cs_ff.burst_cnt + 1'b1;
        end

        if (bus_wr && bus_addr == ADDR_CTRL) begin
            nxt_cs.gate_inhibit = bus_wdata[CTRL_INH];
        end
        if (bus_rd && bus_addr == ADDR_CTRL) begin
            nxt_cs.rdata[CTRL_INH] = cs_ff.gate_inhibit;
        end else if (bus_rd && bus_addr == ADDR_STAT) begin
            nxt_cs.rdata[STAT_SLEEP]        = cs_ff.sleep_en;
            nxt_cs.rdata[STAT_ENC +: 2]     = cs_ff.en_code;
            nxt_cs.rdata[STAT_PRC +: 2]     = cs_ff.thr_code;
            nxt_cs.rdata[STAT_LOWP]         = cs_ff.low_pwr;
            nxt_cs.rdata[STAT_GATE]         = cs_ff.gate_en;
            nxt_cs.rdata[STAT_ENTRY +: 7]   = cs_ff.entry_thr;
            nxt_cs.rdata[STAT_EXIT +: 7]    = cs_ff.exit_thr;
        end

        case (cs_ff.state)
            S_OFF: begin
                nxt_cs.gate_en = 1'b0;
                nxt_cs.low_pwr = 1'b1;
                // A fresh capture follows every exit from S_OFF, which needs enable above its on level and no off condition.
                if (!go_off && cs_ff.filt[PIN_ENON]) begin
                    nxt_cs.state     = S_STRAP;
                    nxt_cs.strap_cnt = '0;
                    nxt_cs.en_full   = 1'b1;
                    nxt_cs.thr_on    = 1'b1;
                end
            end
            S_STRAP: begin
                nxt_cs.strap_cnt = cs_ff.strap_cnt + 1'b1;
                // Sampling only at the end lets the strap voltages settle first.
                if (cs_ff.strap_cnt == STRAP_LAST) begin
                    nxt_cs.en_code   = qcode[0];
                    nxt_cs.thr_code  = qcode[1];
                    nxt_cs.sleep_en  = (qcode[0] != Q_OPEN);
                    nxt_cs.entry_thr = (qcode[0] == Q_R180) ? DUTY_25 : DUTY_40;
                    nxt_cs.exit_thr  = stc_exit_duty(qcode[0] != Q_OPEN, qcode[0],
                                                     qcode[1]);
                    nxt_cs.en_full   = 1'b0;
                    nxt_cs.thr_on    = 1'b0;
                    nxt_cs.state     = S_WAKE;
                    nxt_cs.wake_cnt  = '0;
                end
            end
            S_RUN: begin
                if (burst_det || cs_ff.gate_inhibit) begin
                    nxt_cs.state   = S_LOW;
                    nxt_cs.gate_en = 1'b0;
                    nxt_cs.low_pwr = 1'b1;
                    nxt_cs.ign_cnt = '0;
                end else if (cs_ff.sleep_en && duty_valid) begin
                    if (duty_pct >= cs_ff.entry_thr) begin
                        nxt_cs.sleep_cnt = '0;
                    end else if (cs_ff.sleep_cnt == SLEEP_LAST) begin
                        nxt_cs.state   = S_LOW;
                        nxt_cs.gate_en = 1'b0;
                        nxt_cs.low_pwr = 1'b1;
                        nxt_cs.ign_cnt = IGNORE_SW;
                    end else begin
                        nxt_cs.sleep_cnt = cs_ff.sleep_cnt + 1'b1;
                    end
                end
            end
            S_LOW: begin
                // The first eight duty pulses after a sleep entry are skipped while the output settles.
                if (duty_valid) begin
                    if (cs_ff.ign_cnt != '0) begin
                        nxt_cs.ign_cnt = cs_ff.ign_cnt - 1'b1;
                    end else if (duty_pct > cs_ff.exit_thr && !burst_det &&
                                 !cs_ff.gate_inhibit) begin
                        nxt_cs.state    = S_WAKE;
                        nxt_cs.wake_cnt = '0;
                    end
                end
            end
            S_WAKE: begin
                if (burst_det || cs_ff.gate_inhibit) begin
                    nxt_cs.state = S_LOW;
                end else if (duty_valid) begin
                    if (duty_pct <= cs_ff.exit_thr) begin
                        nxt_cs.state = S_LOW;
                    end else if (cs_ff.wake_cnt == WAKE_LAST) begin
                        nxt_cs.state     = S_RUN;
                        nxt_cs.gate_en   = 1'b1;
                        nxt_cs.low_pwr   = 1'b0;
                        nxt_cs.sleep_cnt = '0;
                    end else begin
                        nxt_cs.wake_cnt = cs_ff.wake_cnt + 1'b1;
                    end
                end
            end
            default: begin
                nxt_cs.state = S_OFF;
            end
        endcase

        // Remote-off or a supply fault overrides every state.
        if (go_off && cs_ff.state != S_OFF) begin
            nxt_cs.state   = S_OFF;
            nxt_cs.gate_en = 1'b0;
            nxt_cs.low_pwr = 1'b1;
            nxt_cs.en_full = 1'b0;
            nxt_cs.thr_on  = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            cs_ff         <= '0;
            cs_ff.state   <= S_OFF;
            cs_ff.low_pwr <= 1'b1;
        end else begin
            cs_ff <= nxt_cs;
        end
    end

    assign bus_rdata                     = cs_ff.rdata;
    assign gate_enable                   = cs_ff.gate_en;
    assign low_power                     = cs_ff.low_pwr;
    assign sleep_enabled                 = cs_ff.sleep_en;
    assign entry_duty                    = cs_ff.entry_thr;
    assign exit_duty                     = cs_ff.exit_thr;
    assign en_sense_full                 = cs_ff.en_full;
    assign threshold_strap_sense_current = cs_ff.thr_on;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b_ff);

    logic strap_done;
    assign strap_done = cs_ff.state == S_STRAP && nxt_cs.state == S_WAKE;

    sleep_enable_a: assert property (strap_done && qcode[0] != Q_OPEN |=> cs_ff.sleep_en)
        else $error("sleep not enabled by resistor strap");
    entry_duty_a: assert property (strap_done && qcode[0] == Q_R180
                                   |=> cs_ff.entry_thr == DUTY_25)
        else $error("wrong sleep entry duty");
    exit_duty100_a: assert property (strap_done && qcode[0] == Q_R100 && qcode[1] == Q_SHORT
                                     |=> cs_ff.exit_thr == DUTY_80)
        else $error("wrong exit duty for 100k strap");
    exit_duty180_a: assert property (strap_done && qcode[0] == Q_R180 && qcode[1] == Q_OPEN
                                     |=> cs_ff.exit_thr == DUTY_55)
        else $error("wrong exit duty for 180k strap");
    sense_drop_a: assert property (cs_ff.state inside {S_RUN, S_LOW, S_WAKE}
                                   |-> !cs_ff.en_full && !cs_ff.thr_on)
        else $error("strap sense current still on");
    sleep_disable_a: assert property (strap_done && qcode[0] == Q_OPEN
                                      |=> !cs_ff.sleep_en)
        else $error("open strap did not disable sleep");
    no_duty_sleep_a: assert property (cs_ff.state == S_RUN && !cs_ff.sleep_en &&
                                      nxt_cs.state == S_LOW
                                      |-> burst_det || cs_ff.gate_inhibit)
        else $error("sleep entered while disabled");
    burst_gate_a: assert property (cs_ff.state == S_RUN && burst_det |=> !gate_enable)
        else $error("gates stayed on in burst");
    burst_exit_a: assert property (strap_done && qcode[0] == Q_OPEN && qcode[1] == Q_OPEN
                                   |=> cs_ff.exit_thr == DUTY_0)
        else $error("wrong burst exit duty");
    burst_detect_a: assert property (burst_det |-> both_high && $past(both_high))
        else $error("burst seen without both senses high");
    restrap_a: assert property (cs_ff.state == S_OFF && nxt_cs.state == S_STRAP
                                |-> cs_ff.filt[PIN_ENON] && !go_off)
        else $error("strap capture without enable");
    sleep_confirm_a: assert property (cs_ff.state == S_RUN && nxt_cs.state == S_LOW &&
                                      !burst_det && !cs_ff.gate_inhibit
                                      |-> cs_ff.sleep_cnt == SLEEP_LAST)
        else $error("sleep entered before confirmation");
    codes_hold_a: assert property (cs_ff.state != S_STRAP && $past(cs_ff.state) != S_STRAP
                                   |-> $stable(cs_ff.sleep_en) && $stable(cs_ff.exit_thr))
        else $error("latched codes changed outside strap phase");

    cover_sleep_c: cover property (cs_ff.state == S_RUN && cs_ff.sleep_en ##1
                                   cs_ff.state == S_LOW);
    cover_burst_c: cover property (cs_ff.state == S_RUN && burst_det ##1 cs_ff.state == S_LOW);
    cover_wake_c:  cover property (cs_ff.state == S_WAKE ##1 cs_ff.state == S_RUN);

endmodule : stc_top

// ===== dv/stc_primary_model.sv
`timescale 1ns/1ps
module stc_primary_model
    import stc_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       arst_n,
    input  wire logic       switching,
    input  wire logic [6:0] duty_set,
    output logic            drain_sense_a,
    output logic            drain_sense_b,
    output logic      [6:0] duty_pct,
    output logic            duty_valid
);
    // ************************************************************
    // Half-bridge seen from the secondary
    // ************************************************************
    logic [1:0] cnt_ff;
    logic       half_ff;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff        <= 2'h0;
            half_ff       <= 1'b0;
            duty_valid    <= 1'b0;
            duty_pct      <= 7'h00;
            drain_sense_a <= 1'b0;
            drain_sense_b <= 1'b0;
        end else begin
            cnt_ff     <= cnt_ff + 2'h1;
            duty_valid <= switching && (cnt_ff == 2'h3);
            // Between pulses the duty bus carries junk, so a stale value is never trusted.
            duty_pct   <= (switching && cnt_ff == 2'h3) ? duty_set : ~duty_pct;
            if (cnt_ff == 2'h3) begin
                half_ff <= ~half_ff;
            end
            // A stopped primary leaves both drains high, which is what burst looks like.
            drain_sense_a <= switching ? half_ff : 1'b1;
            drain_sense_b <= switching ? ~half_ff : 1'b1;
        end
    end
endmodule : stc_primary_model

// ===== dv/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import stc_pkg::*;
;
    // ************************************************************
    // Stimulus and design
    // ************************************************************
    localparam int LIMIT = 90000;
    logic        clock = 1'b0;
    logic        arst_n = 1'b0;
    logic        en_above_on = 1'b0;
    logic        en_below_off = 1'b1;
    logic        supply_in_range = 1'b1;
    logic [7:0]  en_strap_level = 8'h00;
    logic [7:0]  threshold_strap_level = 8'h00;
    logic [3:0]  bus_addr = 4'h0;
    logic [31:0] bus_wdata = 32'h0;
    logic        bus_wr = 1'b0;
    logic        bus_rd = 1'b0;
    logic        model_run = 1'b1;
    logic [6:0]  model_duty = 7'h00;
    logic        drain_sense_a, drain_sense_b, duty_valid, gate_enable, low_power;
    logic        sleep_enabled, en_sense_full, threshold_strap_sense_current;
    logic [6:0]  duty_pct, entry_duty, exit_duty;
    logic [31:0] bus_rdata;
    logic [15:0] rnd = 16'h1690;
    int          n_errors = 0;
    int          cmp_count = 0;
    int          cycles = 0;

    always #2 clock = ~clock;

    stc_top #(.BURST_CYC(50)) i_stc_top (
        .clock(clock), .arst_n(arst_n), .en_above_on(en_above_on),
        .en_below_off(en_below_off), .supply_in_range(supply_in_range),
        .drain_sense_a(drain_sense_a), .drain_sense_b(drain_sense_b),
        .en_strap_level(en_strap_level), .threshold_strap_level(threshold_strap_level),
        .duty_pct(duty_pct), .duty_valid(duty_valid), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .gate_enable(gate_enable), .low_power(low_power), .sleep_enabled(sleep_enabled),
        .entry_duty(entry_duty), .exit_duty(exit_duty), .en_sense_full(en_sense_full),
        .threshold_strap_sense_current(threshold_strap_sense_current));

    stc_primary_model i_stc_primary_model (
        .clock(clock), .arst_n(arst_n), .switching(model_run), .duty_set(model_duty),
        .drain_sense_a(drain_sense_a), .drain_sense_b(drain_sense_b),
        .duty_pct(duty_pct), .duty_valid(duty_valid));

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    // Edge cases pick the top level of a code band, where quantiser slips show.
    function automatic logic [7:0] strap_level(input logic [1:0] c, input logic top);
        logic [7:0] base;
        logic [7:0] span;
        case (c)
            Q_SHORT: begin base = 8'h00; span = 8'h20; end
            Q_R100:  begin base = 8'h20; span = 8'h40; end
            Q_R180:  begin base = 8'h60; span = 8'h40; end
            default: begin base = 8'ha0; span = 8'h60; end
        endcase
        return top ? base + span - 8'h01 : base + rnd[7:0] % span;
    endfunction : strap_level

    function automatic logic [6:0] exp_exit(input logic [1:0] e, input logic [1:0] p);
        logic [6:0] t[4];
        if (e == Q_OPEN) t = '{DUTY_80, DUTY_75, DUTY_65, DUTY_0};
        else if (e == Q_R180) t = '{DUTY_75, DUTY_70, DUTY_60, DUTY_55};
        else t = '{DUTY_80, DUTY_75, DUTY_65, DUTY_60};
        return t[p];
    endfunction : exp_exit

    function automatic logic sel(input int k);
        case (k)
            0:       return gate_enable;
            1:       return low_power;
            default: return en_sense_full;
        endcase
    endfunction : sel

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
            n_errors++;
        end
    endtask : chk

    task automatic wait_chk(input string name, input int k, input logic v, input int n);
        for (int i = 0; i < n && sel(k) !== v; i++) @(posedge clock);
        chk(name, {31'h0, v}, {31'h0, sel(k)});
    endtask : wait_chk

    task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        bus_wr    <= 1'b1;
        bus_addr  <= a;
        bus_wdata <= d;
        @(posedge clock);
        bus_wr    <= 1'b0;
    endtask : bus_write

    task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock);
        bus_rd   <= 1'b1;
        bus_addr <= a;
        @(posedge clock);
        bus_rd   <= 1'b0;
        @(posedge clock);
        d = bus_rdata;
    endtask : bus_read

    task automatic wait_pulses(input int n);
        repeat (n) begin
            @(posedge clock);
            while (duty_valid !== 1'b1) @(posedge clock);
        end
    endtask : wait_pulses

    // Returns on the first pulse that carries the new duty, so that pulse counts as one.
    task automatic set_duty(input logic [6:0] d);
        @(posedge clock);
        model_duty <= d;
        do @(posedge clock); while (!(duty_valid === 1'b1 && duty_pct === d));
    endtask : set_duty

    task automatic capture(input logic [1:0] ec, input logic [1:0] pc);
        @(posedge clock);
        en_below_off <= 1'b1;
        en_above_on  <= 1'b0;
        wait_chk("gate_enable", 0, 1'b0, 10);
        rnd = lfsr_next(rnd);
        en_strap_level <= strap_level(ec, pc == Q_SHORT);
        rnd = lfsr_next(rnd);
        threshold_strap_level <= strap_level(pc, ec == Q_SHORT);
        repeat (4) @(posedge clock);
        en_below_off <= 1'b0;
        en_above_on  <= 1'b1;
        wait_chk("en_sense_full", 2, 1'b1, 20);
        chk("strap_current", 1, threshold_strap_sense_current);
        wait_chk("en_sense_full", 2, 1'b0, 40);
        chk("strap_current", 0, threshold_strap_sense_current);
    endtask : capture

    task automatic print_verdict();
        if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    always @(posedge clock) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_errors++;
            print_verdict();
        end
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        logic [31:0] d;
        logic        slp;
        logic [6:0]  ex;
        logic [6:0]  en;
        repeat (6) @(posedge clock);
        arst_n <= 1'b1;
        repeat (4) @(posedge clock);
        for (int e = 0; e < 4; e++) begin
            for (int p = 0; p < 4; p++) begin
                capture(2'(e), 2'(p));
                slp = (2'(e) != Q_OPEN);
                ex  = exp_exit(2'(e), 2'(p));
                en  = (2'(e) == Q_R180) ? DUTY_25 : DUTY_40;
                chk("sleep_enabled", {31'h0, slp}, {31'h0, sleep_enabled});
                if (slp) chk("entry_duty", en, entry_duty);
                chk("exit_duty", ex, exit_duty);
                bus_read(ADDR_STAT, d);
                chk("status_codes", {p[1:0], e[1:0], slp}, d[4:0]);
                chk("status_exit", ex, d[22:16]);
                bus_read(4'h8, d);
                chk("unmapped_read", 0, d);
                rnd = lfsr_next(rnd);
                threshold_strap_level <= rnd[15:8];
                en_strap_level        <= rnd[7:0];
                set_duty(ex + 7'h0a);
                wait_chk("gate_enable", 0, 1'b1, 300);
                chk("low_power", 0, low_power);
                bus_write(ADDR_CTRL, 32'h1);
                wait_chk("gate_enable", 0, 1'b0, 8);
                bus_read(ADDR_CTRL, d);
                chk("ctrl", 1, d);
                bus_write(ADDR_CTRL, 32'h0);
                wait_chk("gate_enable", 0, 1'b1, 300);
                set_duty(slp ? en - 7'h01 : 7'h05);
                wait_pulses(510);
                repeat (2) @(posedge clock);
                chk("gate_enable", 1, gate_enable);
                if (slp) begin
                    wait_pulses(1);
                    wait_chk("low_power", 1, 1'b1, 8);
                    chk("gate_enable", 0, gate_enable);
                    set_duty(ex + 7'h01);
                    wait_chk("gate_enable", 0, 1'b1, 400);
                end else begin
                    wait_pulses(100);
                    chk("gate_enable", 1, gate_enable);
                end
                @(posedge clock);
                model_run <= 1'b0;
                repeat (44) @(posedge clock);
                chk("gate_enable", 1, gate_enable);
                wait_chk("gate_enable", 0, 1'b0, 30);
                wait_chk("low_power", 1, 1'b1, 4);
                model_duty <= ex;
                model_run  <= 1'b1;
                wait_pulses(40);
                chk("gate_enable", 0, gate_enable);
                model_duty <= ex + 7'h01;
                wait_chk("gate_enable", 0, 1'b1, 300);
                chk("exit_duty", ex, exit_duty);
            end
        end
        print_verdict();
    end
endmodule : tb_top
